/* File: verilog/rpba_regs.vh */
// Purpose: Constants for the rotating priority bus arbiter
// Assumes: 40 MHz clock, active low request and bus-busy lines
// Notes: Program addresses are seven bits for a 128 word store
`ifndef RPBA_REGS_VH
`define RPBA_REGS_VH
`define RPBA_PC_W 7
`define RPBA_PROG_DEPTH 128
`define RPBA_PROG_USED 112
`define RPBA_TABLE_SPAN 64
`define RPBA_IDLE_T1 7'h0F
`define RPBA_IDLE_T2 7'h1F
`define RPBA_IDLE_T3 7'h2F
`define RPBA_IDLE_T4 7'h3F
`define RPBA_PON_ADDR 7'h3F
`define RPBA_REQ_NONE 4'hF
`define RPBA_GRANT_NONE 4'hF
`define RPBA_SEL_T1 2'h0
`define RPBA_IDLE_LOW 4'hF
`define RPBA_GRANT_BASE 7'h40
`define RPBA_TABLE_STEPS 7'h0C
`define RPBA_OWNER_STEPS 7'h03
`define RPBA_STEP_HOLD 7'h01
`define RPBA_STEP_REL 7'h02
`endif

/* File: verilog/rpba_jump_rom.v */
// Purpose: Jump table store, one entry per table and request pattern
// Assumes: Index is table select and the registered request pattern
// Notes: Read data comes out of a register
`timescale 1ns/10ps
`default_nettype none
module rpba_jump_rom (
    input wire clk, // System clock
    input wire [5:0] addr, // Table select and request pattern
    output reg [1:0] data // Winning requester, 0 means cpu1
);
    // Highest ranked active requester; request bits active low
    function [1:0] pick;
        input [5:0] a;
        reg [1:0] k;
        reg [1:0] cand;
        reg found;
        integer i;
        begin
            pick = 2'h0;
            found = 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                k = i[1:0];
                cand = a[5:4] + k;
                if (!found && !a[cand]) begin
                    pick = cand;
                    found = 1'b1;
                end
            end
        end
    endfunction
    // Registered table read
    always @(posedge clk) begin
        data <= pick(addr);
    end
endmodule
`default_nettype wire

/* File: verilog/rpba_arbiter.v */
// Purpose: Four requester bus arbiter rotating through four priority tables
// Assumes: Request and bus-busy lines are active low and synchronous to clk
// Notes: Program counter values mirror the microprogram layout
`timescale 1ns/10ps
`default_nettype none
`include "rpba_regs.vh"
module rpba_arbiter (
    input wire clk, // 40 MHz clock
    input wire rstn, // Active low asynchronous reset
    input wire request_line_cpu1, // Request, active low
    input wire request_line_cpu2, // Request, active low
    input wire request_line_cpu3, // Request, active low
    input wire request_line_cpu4, // Request, active low
    input wire bus_busy_line, // Bus busy, active low
    output reg grant_line_cpu1, // Grant, active low
    output reg grant_line_cpu2, // Grant, active low
    output reg grant_line_cpu3, // Grant, active low
    output reg grant_line_cpu4, // Grant, active low
    output reg [1:0] table_select, // Active priority table
    output reg [`RPBA_PC_W-1:0] program_counter, // Current location
    output reg [3:0] count_register // Counter loaded from test inputs
);
    localparam ST_PON = 6'h01;
    localparam ST_IDLE = 6'h02;
    localparam ST_DISP = 6'h04;
    localparam ST_WBUSY = 6'h08;
    localparam ST_HOLD = 6'h10;
    localparam ST_REL = 6'h20;

    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    reg [5:0] state;
    reg [5:0] next_state;
    reg [3:0] test_reg;
    reg busy_reg;
    reg [1:0] owner;
    wire [1:0] rom_data;
    wire [3:0] grant_vec;
    wire [1:0] grant_owner;
    wire grant_on;
    wire advance;
    wire [1:0] next_table;
    wire [1:0] idle_table;
    wire [`RPBA_PC_W-1:0] grant_loc;

    // Reset release through two flip-flops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Test inputs captured each clock
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_reg <= `RPBA_REQ_NONE;
            busy_reg <= 1'b1;
        end else begin
            test_reg <= {request_line_cpu4, request_line_cpu3,
                request_line_cpu2, request_line_cpu1};
            busy_reg <= bus_busy_line;
        end
    end

    // Jump table indexed by fed back select and registered requests
    rpba_jump_rom u_rom (
        .clk(clk),
        .addr({table_select, test_reg}),
        .data(rom_data)
    );

    // Next step of the arbitration sequence
    always @* begin
        next_state = state;
        case (state)
            ST_PON: begin
                if (busy_reg) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (busy_reg && test_reg != `RPBA_REQ_NONE) begin
                    next_state = ST_DISP;
                end
            end
            ST_DISP: begin
                next_state = ST_WBUSY;
            end
            ST_WBUSY: begin
                if (!busy_reg) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (test_reg[owner]) begin
                    next_state = ST_REL;
                end
            end
            ST_REL: begin
                if (busy_reg) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_PON;
            end
        endcase
    end


    // Requester that the registered grant lines point at from the next clock
    assign grant_owner = (state == ST_DISP) ? rom_data : owner;
    assign grant_vec = ~(4'h1 << grant_owner);
    // Grant shows while waiting for busy low and while the owner holds
    assign grant_on = (next_state == ST_WBUSY) || (next_state == ST_HOLD);

    // The table steps once, when a release completes with bus-busy high
    assign advance = (state == ST_REL) && busy_reg;
    assign next_table = table_select + 2'h1;
    // Idle must already carry the new table, else its location lands in the previous table
    assign idle_table = advance ? next_table : table_select;

    // Grant steps sit above the jump tables, three per requester per table
    assign grant_loc = `RPBA_GRANT_BASE + {5'h0, table_select} * `RPBA_TABLE_STEPS
        + {5'h0, grant_owner} * `RPBA_OWNER_STEPS;

    // Sequencer state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_PON;
        end else begin
            state <= next_state;
        end
    end

    // Winner latched when its jump table entry is used
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owner <= 2'h0;
        end else begin
            if (state == ST_DISP) begin
                owner <= rom_data;
            end
        end
    end

    // Count register follows the test register, so it lags the pins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_register <= 4'h0;
        end else begin
            count_register <= test_reg;
        end
    end

    // Grant lines, active low, all high outside a grant
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {grant_line_cpu4, grant_line_cpu3, grant_line_cpu2,
                grant_line_cpu1} <= `RPBA_GRANT_NONE;
        end else begin
            if (grant_on) begin
                {grant_line_cpu4, grant_line_cpu3, grant_line_cpu2,
                    grant_line_cpu1} <= grant_vec;
            end else begin
                {grant_line_cpu4, grant_line_cpu3, grant_line_cpu2,
                    grant_line_cpu1} <= `RPBA_GRANT_NONE;
            end
        end
    end

    // Priority table rotation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table_select <= `RPBA_SEL_T1;
        end else begin
            if (advance) begin
                table_select <= next_table;
            end
        end
    end

    // Program location of the step about to run
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_counter <= `RPBA_PON_ADDR;
        end else begin
            case (next_state)
                ST_PON: begin
                    program_counter <= `RPBA_PON_ADDR;
                end
                ST_IDLE: begin
                    program_counter <= {1'b0, idle_table, `RPBA_IDLE_LOW};
                end
                ST_WBUSY: begin
                    program_counter <= grant_loc;
                end
                ST_HOLD: begin
                    program_counter <= grant_loc + `RPBA_STEP_HOLD;
                end
                ST_REL: begin
                    program_counter <= grant_loc + `RPBA_STEP_REL;
                end
                default: begin
                    program_counter <= {1'b0, table_select, test_reg};
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verification/rpba_props.sv */
// Purpose: Port checks for the arbiter
// Assumes: Far side holds a request until served
// Notes: Bound from the bench
`timescale 1ns/10ps
`default_nettype none
module rpba_props (
    input wire clk, input wire rstn, input wire bus_busy_line, // Clock, reset, busy
    input wire request_line_cpu1, input wire request_line_cpu2, // Requests
    input wire request_line_cpu3, input wire request_line_cpu4, // Requests
    input wire grant_line_cpu1, input wire grant_line_cpu2, // Grants
    input wire grant_line_cpu3, input wire grant_line_cpu4, // Grants
    input wire [1:0] table_select, input wire [6:0] program_counter, // State
    input wire [3:0] count_register // Count
);
wire [3:0] rq = {request_line_cpu4, request_line_cpu3, request_line_cpu2, request_line_cpu1};
wire [3:0] gr = {grant_line_cpu4, grant_line_cpu3, grant_line_cpu2, grant_line_cpu1};
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
property p_one; $countones(~gr) <= 1; endproperty
a_one: assert property (p_one) else $error("two grants");
property p_hold; !grant_line_cpu1 && !request_line_cpu1 |=> !grant_line_cpu1; endproperty
a_hold: assert property (p_hold) else $error("grant dropped");
property p_free; $rose(request_line_cpu1) && !grant_line_cpu1 |-> ##[1:3] grant_line_cpu1; endproperty
a_free: assert property (p_free) else $error("grant kept");
property p_rst; $rose(rstn) |-> program_counter == 7'h3F && gr == 4'hF; endproperty
a_rst: assert property (p_rst) else $error("bad reset");
property p_cause; $fell(grant_line_cpu2) |-> !$past(request_line_cpu2, 2); endproperty
a_cause: assert property (p_cause) else $error("grant unasked");
property p_adv; $changed(table_select) |-> table_select == $past(table_select) + 2'h1; endproperty
a_adv: assert property (p_adv) else $error("table skip");
property p_stay; program_counter == 7'h2F && $past(rq) == 4'hF |=> program_counter == 7'h2F; endproperty
a_stay: assert property (p_stay) else $error("idle left");
property p_range; program_counter < 7'h70; endproperty
a_range: assert property (p_range) else $error("pc range");
property p_cnt; rstn && $past(rstn) && $past(rstn, 2) && $past(rstn, 3) && $past(rstn, 4)
    |-> count_register == $past(rq, 2); endproperty
a_cnt: assert property (p_cnt) else $error("count lag");
endmodule
`default_nettype wire

/* File: verification/rpba_cpus.sv */
// Purpose: Four bus requesting processors
// Assumes: Bench sets want per processor
// Notes: Request drops after four busy cycles; bus is held until the grant drops
`timescale 1ns/10ps
`default_nettype none
module rpba_cpus (
    input wire clk, // Clock
    input wire [3:0] want, // Processor wants the bus
    input wire [3:0] grant_n, // Grants, active low
    output wire [3:0] req_n, // Requests, active low
    output reg bus_busy_n // Bus busy, active low
);
reg [3:0] done;
reg [1:0] owner;
reg [2:0] cnt;
assign req_n = ~(want & ~done);
initial begin bus_busy_n = 1'b1; done = 4'h0; owner = 2'h0; cnt = 3'h0; end
// Take bus on grant, drop request, free bus once grant is gone
always @(negedge clk) begin
    done <= done & want;
    if (bus_busy_n && grant_n != 4'hF) begin
        bus_busy_n <= 1'b0;
        owner <= {~grant_n[3] | ~grant_n[2], ~grant_n[3] | ~grant_n[1]};
    end else if (!bus_busy_n) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h3) done[owner] <= 1'b1;
        if (done[owner] && grant_n[owner]) begin
            bus_busy_n <= 1'b1;
            cnt <= 3'h0;
        end
    end
end
endmodule
`default_nettype wire

/* File: verification/test_rotating_priority_bus_arbiter.sv */
// Purpose: Bench for the arbiter
// Assumes: Inputs change on falling edges
// Notes: Tracks the expected table
`timescale 1ns/10ps
`default_nettype none
module test_rotating_priority_bus_arbiter;
reg clk; reg rstn; reg [3:0] want; reg [1:0] tab;
wire [3:0] rq; wire [3:0] gr; wire bb; wire [1:0] tsel; wire [6:0] pc;
integer n_fail; integer comparisons; integer cyc; integer i;
rpba_arbiter dut (.clk(clk), .rstn(rstn), .request_line_cpu1(rq[0]), .request_line_cpu2(rq[1]),
    .request_line_cpu3(rq[2]), .request_line_cpu4(rq[3]), .bus_busy_line(bb),
    .grant_line_cpu1(gr[0]), .grant_line_cpu2(gr[1]), .grant_line_cpu3(gr[2]),
    .grant_line_cpu4(gr[3]), .table_select(tsel), .program_counter(pc), .count_register());
rpba_cpus far (.clk(clk), .want(want), .grant_n(gr), .req_n(rq), .bus_busy_n(bb));
initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
// Cut a hang short
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin n_fail = n_fail + 1; close_out; end
end
task chk(input [39:0] what, input [6:0] exp, input [6:0] got); begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s exp %h got %h", what, exp, got);
    end
end endtask
task arb(input [3:0] w, input [3:0] g); integer k; begin
    want = w; k = 0;
    while (gr === 4'hF && k < 40) begin @(negedge clk); k = k + 1; end
    chk("grant", {3'h0, g}, {3'h0, gr});
    want = w & ~g;
    while (tsel === tab && k < 90) begin @(negedge clk); k = k + 1; end
    tab = tab + 2'h1;
    chk("table", {5'h0, tab}, {5'h0, tsel});
    want = 4'h0; @(negedge clk);
end endtask
task t_idle; begin
    repeat (20) @(negedge clk);
    chk("pc", 7'h0F, pc);
    chk("grant", 7'h0F, {3'h0, gr});
end endtask
task t_top; for (i = 0; i < 4; i = i + 1) arb(4'hF, ~(4'h1 << i)); endtask
task t_second; for (i = 0; i < 4; i = i + 1)
    arb(4'hF & ~(4'h1 << i), ~(4'h1 << ((i + 1) & 3))); endtask
task t_reset; begin
    want = 4'h4; repeat (3) @(negedge clk);
    rstn = 1'b0; @(negedge clk);
    chk("pc", 7'h3F, pc);
    chk("table", 7'h00, {5'h0, tsel});
    rstn = 1'b1; want = 4'h0; tab = 2'h0; repeat (20) @(negedge clk);
    arb(4'h8, 4'h7);
end endtask
task close_out; begin
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
end endtask
initial begin
    rstn = 1'b0; want = 4'h0; tab = 2'h0; n_fail = 0; comparisons = 0; cyc = 0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_idle; t_top; t_second; t_reset;
    close_out;
end
endmodule
bind rpba_arbiter rpba_props chk_i (.*);
`default_nettype wire
